// *** design/fdc_defines.svh ***
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Memory-mapped request-select registers (byte addresses)
// ----------------------------------------------------------------------------
`define FDC_SEL0_ADDR 16'h0378
`define FDC_SEL1_ADDR 16'h0379
`define FDC_SEL2_ADDR 16'h037a
`define FDC_SEL3_ADDR 16'h037b
`define FDC_SEL_RESET 8'h00
`define FDC_SEL_SRC_LSB 0
`define FDC_SEL_SRC_MSB 4
`define FDC_SEL_LEG_SRC_MSB 3
`define FDC_SEL_SWREQ_BIT 5
`define FDC_SEL_EXP_BIT 6
`define FDC_SEL_PEND_BIT 7

// ----------------------------------------------------------------------------
// Control-register load codes
// ----------------------------------------------------------------------------
`define FDC_LDC_MODE 3'h0
`define FDC_LDC_FIXED 3'h1
`define FDC_LDC_MEMADDR 3'h2
`define FDC_LDC_COUNT 3'h3
`define FDC_LDC_ADDR_RELOAD 3'h4
`define FDC_LDC_COUNT_RELOAD 3'h5

// ----------------------------------------------------------------------------
// Channel mode register fields
// ----------------------------------------------------------------------------
`define FDC_MODE_DIR_BIT 0
`define FDC_MODE_REPEAT_BIT 1
`define FDC_MODE_FIXFIX_BIT 2
`define FDC_MODE_WORD_BIT 3
`define FDC_MODE_RESET 4'h0

// ----------------------------------------------------------------------------
// Counter and address constants
// ----------------------------------------------------------------------------
`define FDC_CNT_ONE 16'h0001
`define FDC_CNT_ZERO 16'h0000
`define FDC_ADDR_MASK_FULL 24'hffffff
`define FDC_ADDR_MASK_LEGACY 24'h0fffff
`define FDC_ADDR_RESET 24'h000000

`endif

// *** design/fdc_pkg.sv ***
package fdc_pkg;
  typedef enum logic [2:0] {
    FDC_IDLE = 3'b000,
    FDC_READ = 3'b001,
    FDC_WRITE = 3'b011,
    FDC_RLD_ADDR = 3'b010,
    FDC_RLD_CNT = 3'b110
  } fdc_state_type;
  typedef logic [23:0] fdc_addr_type;
  typedef logic [15:0] fdc_count_type;
endpackage

// *** design/fdc_reload_if.sv ***
`timescale 1ns/100ps
interface fdc_reload_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [23:0] wr_data;
  logic [2:0] rd_idx_a;
  logic [23:0] rd_data_a;
  logic [2:0] rd_idx_b;
  logic [23:0] rd_data_b;
  modport user (output wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b, input rd_data_a, rd_data_b);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b, output rd_data_a, rd_data_b);
endinterface

// *** design/fdc_reload_mem.sv ***
`timescale 1ns/100ps
module fdc_reload_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  fdc_reload_if.mem port
);
  logic [WIDTH-1:0] store [DEPTH];

  // ----------------------------------------------------------------------------
  // One write port, two registered read ports
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      store[port.wr_idx] <= port.wr_data;
    end
    port.rd_data_a <= store[port.rd_idx_a];
    port.rd_data_b <= store[port.rd_idx_b];
  end
endmodule // fdc_reload_mem

// *** design/fdc_dma_controller.sv ***
`timescale 1ns/100ps
`include "fdc_defines.svh"
// Function
// - Four channels 0 to 3, each doing exactly the loaded number of transfers.
// - A channel's interrupt pulses when its counter steps from 0001h to 0000h.
// - The legacy build does the loaded count plus one transfers on channels 0 and 1.
// - The legacy build pulses the interrupt when the counter underflows below zero.
// - Transfers go from any 16-Mbyte address to a fixed one, or the reverse.
// - The legacy build limits addresses to 1 Mbyte and adds fixed-to-fixed moves.
// - Each channel's request source comes from the select field of its select register.
// - The legacy build forms the source from the expansion bit 6 and bits 0-3.
// - Repeat mode reloads memory address and count from the reload registers per block.
// - Fixed and memory-side addresses sit in separate registers; direction picks roles.
// - Mode, fixed-address and reload registers are written only by the load port; the engine also steps memory address and count.
module fdc_dma_controller import fdc_pkg::*; #(
  parameter bit LEGACY = 1'b0,
  parameter int NUM_SRC = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic ldc_wr,
  input wire logic ldc_rd,
  input wire logic [1:0] ldc_chan,
  input wire logic [2:0] ldc_code,
  input wire logic [23:0] ldc_wdata,
  output logic [23:0] ldc_rdata,
  output logic ldc_rvalid,
  input wire logic [NUM_SRC-1:0] periph_req,
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [3:0] dma_irq
);
  localparam fdc_addr_type AMASK = LEGACY ? `FDC_ADDR_MASK_LEGACY : `FDC_ADDR_MASK_FULL;
  localparam int NCH = LEGACY ? 2 : 4;

  fdc_state_type state, next_state;
  logic [1:0] gch, next_gch;
  logic next_mem_req, next_mem_we, next_mem_word;
  logic [23:0] next_mem_addr;
  logic [15:0] next_mem_wdata;
  logic [3:0] next_irq;
  logic [3:0] act, next_act, pend, next_pend;
  logic [4:0] src_sel [4];
  logic [4:0] next_src_sel [4];
  logic [3:0] mode [4];
  logic [3:0] next_mode [4];
  fdc_addr_type fixed_addr [4];
  fdc_addr_type next_fixed_addr [4];
  fdc_addr_type mem_side [4];
  fdc_addr_type next_mem_side [4];
  fdc_count_type cnt [4];
  fdc_count_type next_cnt [4];
  logic [7:0] next_sfr_rdata;
  logic rd_pend, rd_reload;
  logic [23:0] rd_live, next_rd_live, next_ldc_rdata;
  fdc_reload_if rl();

  function automatic logic sel_hit(input logic [15:0] a, input int i);
    sel_hit = (a == (`FDC_SEL0_ADDR + 16'(i)));
  endfunction

  function automatic logic fix_both(input logic [3:0] m);
    fix_both = LEGACY && m[`FDC_MODE_FIXFIX_BIT];
  endfunction

  fdc_reload_mem #(.WIDTH(24), .DEPTH(8)) u_reload (
    .clk(clk),
    .port(rl.mem)
  );

  // ----------------------------------------------------------------------------
  // Reload storage ports
  // ----------------------------------------------------------------------------
  assign rl.wr_en = ldc_wr && (int'(ldc_chan) < NCH) && (ldc_code == `FDC_LDC_ADDR_RELOAD
                               || ldc_code == `FDC_LDC_COUNT_RELOAD);
  assign rl.wr_idx = {ldc_code == `FDC_LDC_COUNT_RELOAD, ldc_chan};
  assign rl.wr_data = (ldc_code == `FDC_LDC_ADDR_RELOAD) ? (ldc_wdata & AMASK) : ldc_wdata;
  // Address reload is fetched during the write, the count reload one cycle later
  assign rl.rd_idx_a = {state != FDC_WRITE, gch};
  assign rl.rd_idx_b = {ldc_code == `FDC_LDC_COUNT_RELOAD, ldc_chan};

  // ----------------------------------------------------------------------------
  // Transfer engine and channel state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic found;
    logic [1:0] g;
    logic ff;
    logic blk_end;
    fdc_addr_type step;
    found = 1'b0;
    g = 2'd0;
    ff = 1'b0;
    blk_end = 1'b0;
    step = 24'h000001;
    next_state = state;
    next_gch = gch;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_word = mem_word;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_irq = 4'h0;
    next_act = act;
    for (int i = 0; i < 4; i++) begin
      next_src_sel[i] = src_sel[i];
      next_mode[i] = mode[i];
      next_fixed_addr[i] = fixed_addr[i];
      next_mem_side[i] = mem_side[i];
      next_cnt[i] = cnt[i];
    end
    // Fixed priority: channel 0 wins; only active channels are served
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend[i] && act[i]) begin
        found = 1'b1;
        g = 2'(i);
      end
    end
    case (state)
      FDC_IDLE: begin
        if (found) begin
          ff = fix_both(mode[g]);
          next_gch = g;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_word = mode[g][`FDC_MODE_WORD_BIT];
          next_mem_addr = (mode[g][`FDC_MODE_DIR_BIT] || ff) ? fixed_addr[g]
                                                             : mem_side[g];
          next_state = FDC_READ;
        end
      end
      FDC_READ: begin
        if (mem_ack) begin
          ff = fix_both(mode[gch]);
          next_mem_wdata = mem_rdata;
          next_mem_we = 1'b1;
          next_mem_addr = (mode[gch][`FDC_MODE_DIR_BIT] || ff) ? mem_side[gch]
                                                               : fixed_addr[gch];
          next_state = FDC_WRITE;
        end
      end
      FDC_WRITE: begin
        if (mem_ack) begin
          ff = fix_both(mode[gch]);
          step = mode[gch][`FDC_MODE_WORD_BIT] ? 24'h000002 : 24'h000001;
          next_mem_req = 1'b0;
          next_mem_we = 1'b0;
          if (!ff) begin
            next_mem_side[gch] = (mem_side[gch] + step) & AMASK;
          end
          if (LEGACY) begin
            blk_end = (cnt[gch] == `FDC_CNT_ZERO);
          end else begin
            blk_end = (cnt[gch] == `FDC_CNT_ONE);
          end
          next_cnt[gch] = cnt[gch] - `FDC_CNT_ONE;
          next_irq[gch] = blk_end;
          if (blk_end && mode[gch][`FDC_MODE_REPEAT_BIT]) begin
            next_state = FDC_RLD_ADDR;
          end else begin
            if (blk_end) begin
              next_act[gch] = 1'b0;
            end
            next_state = FDC_IDLE;
          end
        end
      end
      FDC_RLD_ADDR: begin
        next_mem_side[gch] = rl.rd_data_a & AMASK;
        next_state = FDC_RLD_CNT;
      end
      FDC_RLD_CNT: begin
        next_cnt[gch] = rl.rd_data_a[15:0];
        next_act[gch] = LEGACY || (rl.rd_data_a[15:0] != `FDC_CNT_ZERO);
        next_state = FDC_IDLE;
      end
      default: begin
        next_state = FDC_IDLE;
        next_mem_req = 1'b0;
      end
    endcase
    // Software loads override the engine on the same cycle
    if (ldc_wr && (int'(ldc_chan) < NCH)) begin
      case (ldc_code)
        `FDC_LDC_MODE: next_mode[ldc_chan] = ldc_wdata[3:0];
        `FDC_LDC_FIXED: next_fixed_addr[ldc_chan] = ldc_wdata & AMASK;
        `FDC_LDC_MEMADDR: next_mem_side[ldc_chan] = ldc_wdata & AMASK;
        `FDC_LDC_COUNT: begin
          next_cnt[ldc_chan] = ldc_wdata[15:0];
          // Legacy zero still means one transfer; otherwise zero leaves it idle
          next_act[ldc_chan] = LEGACY || (ldc_wdata[15:0] != `FDC_CNT_ZERO);
        end
        default: begin
        end
      endcase
    end
    // Request capture: a new request wins over the clear by the grant
    for (int i = 0; i < 4; i++) begin
      logic sw_req;
      sw_req = sfr_wr && sel_hit(sfr_addr, i) && sfr_wdata[`FDC_SEL_SWREQ_BIT];
      next_pend[i] = next_act[i] && (((periph_req[src_sel[i]] || sw_req) && act[i])
                     || (pend[i] && !(state == FDC_IDLE && found && g == 2'(i))));
      if (sfr_wr && sel_hit(sfr_addr, i)) begin
        if (LEGACY) begin
          next_src_sel[i] = {sfr_wdata[`FDC_SEL_EXP_BIT],
                             sfr_wdata[`FDC_SEL_LEG_SRC_MSB:`FDC_SEL_SRC_LSB]};
        end else begin
          next_src_sel[i] = sfr_wdata[`FDC_SEL_SRC_MSB:`FDC_SEL_SRC_LSB];
        end
      end
      if (i >= NCH) begin
        next_pend[i] = 1'b0;
        next_act[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= FDC_IDLE;
      gch <= 2'd0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= `FDC_ADDR_RESET;
      mem_wdata <= 16'h0000;
      dma_irq <= 4'h0;
      act <= 4'h0;
      pend <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        src_sel[i] <= 5'h00;
        mode[i] <= `FDC_MODE_RESET;
        fixed_addr[i] <= `FDC_ADDR_RESET;
        mem_side[i] <= `FDC_ADDR_RESET;
        cnt[i] <= `FDC_CNT_ZERO;
      end
    end else begin
      state <= next_state;
      gch <= next_gch;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_word <= next_mem_word;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      dma_irq <= next_irq;
      act <= next_act;
      pend <= next_pend;
      for (int i = 0; i < 4; i++) begin
        src_sel[i] <= next_src_sel[i];
        mode[i] <= next_mode[i];
        fixed_addr[i] <= next_fixed_addr[i];
        mem_side[i] <= next_mem_side[i];
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read-back of both register sets
  // ----------------------------------------------------------------------------
  always_comb begin
    next_sfr_rdata = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (sfr_rd && sel_hit(sfr_addr, i)) begin
        // Software-request bit always reads zero; bit 6 reserved unless legacy
        next_sfr_rdata[`FDC_SEL_PEND_BIT] = pend[i];
        if (LEGACY) begin
          next_sfr_rdata[`FDC_SEL_EXP_BIT] = src_sel[i][4];
          next_sfr_rdata[3:0] = src_sel[i][3:0];
        end else begin
          next_sfr_rdata[4:0] = src_sel[i];
        end
      end
    end
    case (ldc_code)
      `FDC_LDC_MODE: next_rd_live = {20'h00000, mode[ldc_chan]};
      `FDC_LDC_FIXED: next_rd_live = fixed_addr[ldc_chan];
      `FDC_LDC_MEMADDR: next_rd_live = mem_side[ldc_chan];
      `FDC_LDC_COUNT: next_rd_live = {8'h00, cnt[ldc_chan]};
      default: next_rd_live = 24'h000000;
    endcase
    next_ldc_rdata = rd_reload ? rl.rd_data_b : rd_live;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      rd_pend <= 1'b0;
      rd_reload <= 1'b0;
      rd_live <= 24'h000000;
      ldc_rdata <= 24'h000000;
      ldc_rvalid <= 1'b0;
    end else begin
      sfr_rdata <= next_sfr_rdata;
      rd_pend <= ldc_rd;
      rd_reload <= ldc_code == `FDC_LDC_ADDR_RELOAD || ldc_code == `FDC_LDC_COUNT_RELOAD;
      rd_live <= next_rd_live;
      ldc_rdata <= rd_pend ? next_ldc_rdata : ldc_rdata;
      ldc_rvalid <= rd_pend;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  chk_irq_last_step: assert property (@(posedge clk) disable iff (sys_rst)
    (!LEGACY && state == FDC_WRITE && mem_ack && cnt[gch] == `FDC_CNT_ONE)
    |=> dma_irq == (4'h1 << $past(gch)))
    else $error("interrupt missing on last transfer");
  chk_irq_cause_only: assert property (@(posedge clk) disable iff (sys_rst)
    (dma_irq != 4'h0) |-> $past(state) == FDC_WRITE && $past(mem_ack))
    else $error("interrupt without completed transfer");
  chk_count_step: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FDC_WRITE && mem_ack && !ldc_wr) |=> cnt[gch] == $past(cnt[gch]) - 16'h0001
      || state == FDC_RLD_ADDR)
    else $error("counter did not step by one");
  chk_legacy_uflow: assert property (@(posedge clk) disable iff (sys_rst)
    (LEGACY && state == FDC_WRITE && mem_ack && cnt[gch] == `FDC_CNT_ZERO) |=> dma_irq[gch])
    else $error("legacy underflow interrupt missing");
  chk_grant_active: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FDC_IDLE && next_state == FDC_READ) |-> act[next_gch])
    else $error("inactive channel served");
  chk_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
    mem_req |-> (mem_addr & ~AMASK) == 24'h000000)
    else $error("address outside space");
  chk_write_target: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FDC_WRITE && mem_req && !fix_both(mode[gch]))
    |-> mem_addr == (mode[gch][0] ? $past(mem_side[gch]) : $past(fixed_addr[gch]))
      || $past(ldc_wr))
    else $error("write address does not follow direction");
  chk_repeat_reload: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FDC_WRITE && mem_ack && !ldc_wr && mode[gch][1]
     && cnt[gch] == (LEGACY ? `FDC_CNT_ZERO : `FDC_CNT_ONE))
    |=> state == FDC_RLD_ADDR ##2 state == FDC_IDLE && cnt[gch] == $past(rl.rd_data_a[15:0]))
    else $error("repeat reload not applied");
  chk_sw_request: assert property (@(posedge clk) disable iff (sys_rst)
    (sfr_wr && sfr_addr == `FDC_SEL0_ADDR && sfr_wdata[5] && act[0] && next_act[0])
    |=> pend[0])
    else $error("software request lost");
  chk_mode_load_only: assert property (@(posedge clk) disable iff (sys_rst)
    !ldc_wr |=> $stable(mode[0]) && $stable(fixed_addr[0]))
    else $error("control register changed without load");
  chk_req_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr))
    else $error("bus request dropped early");
  cov_repeat: cover property (@(posedge clk) state == FDC_RLD_CNT);
  cov_irq: cover property (@(posedge clk) dma_irq != 4'h0);
  cov_sw_grant: cover property (@(posedge clk)
    sfr_wr && sfr_wdata[5] ##[1:4] state == FDC_READ);
endmodule // fdc_dma_controller

// *** test/fdc_mem_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Memory bus responder with a settable wait before each ack
// ----------------------------------------------------------------------------
module fdc_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] wait_cycles,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [3:0] wait_cnt;

  // Data follows the address, so a logged write shows where it was read
  function automatic logic [15:0] fdc_pattern(input logic [23:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction

  // Outside an ack the bus holds nothing valid
  assign mem_rdata = mem_ack ? fdc_pattern(mem_addr) : ~fdc_pattern(mem_addr);

  always @(posedge clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (mem_req) begin
      if (wait_cnt >= wait_cycles) begin
        mem_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // fdc_mem_model

// *** test/testbench.sv ***
`timescale 1ns/100ps
`include "fdc_defines.svh"
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin bad_count++; $display("Error %s expected %h seen %h", nm, ex, sn); end end
module testbench import fdc_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] sfr_addr = 16'h0000;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic ldc_wr = 1'b0;
  logic ldc_rd = 1'b0;
  logic [1:0] ldc_chan = 2'h0;
  logic [2:0] ldc_code = 3'h0;
  logic [23:0] ldc_wdata = 24'h000000;
  logic [31:0] periph_req = 32'h00000000;
  logic [3:0] wait_cycles = 4'h0;
  logic [7:0] sfr_rdata [2];
  logic [23:0] ldc_rdata [2];
  logic [1:0] ldc_rvalid, mem_req, mem_we, mem_word, mem_ack;
  fdc_addr_type mem_addr [2];
  fdc_count_type mem_wdata [2];
  fdc_count_type mem_rdata [2];
  logic [3:0] dma_irq [2];
  fdc_addr_type wlog_a [2][$];
  fdc_count_type wlog_d [2][$];
  logic wlog_w [2][$];
  int irq_n [2][4];
  int bad_count = 0;
  int checks_done = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Instance 0 is the four-channel build, instance 1 the legacy build
  // ----------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gen_dut
    fdc_dma_controller #(.LEGACY(g == 1), .NUM_SRC(32)) uut (
      .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata[g]), .ldc_wr(ldc_wr), .ldc_rd(ldc_rd),
      .ldc_chan(ldc_chan), .ldc_code(ldc_code), .ldc_wdata(ldc_wdata),
      .ldc_rdata(ldc_rdata[g]), .ldc_rvalid(ldc_rvalid[g]), .periph_req(periph_req),
      .mem_req(mem_req[g]), .mem_we(mem_we[g]), .mem_word(mem_word[g]),
      .mem_addr(mem_addr[g]), .mem_wdata(mem_wdata[g]), .mem_rdata(mem_rdata[g]),
      .mem_ack(mem_ack[g]), .dma_irq(dma_irq[g]));
    fdc_mem_model part (
      .clk(clk), .sys_rst(sys_rst), .wait_cycles(wait_cycles), .mem_req(mem_req[g]),
      .mem_addr(mem_addr[g]), .mem_rdata(mem_rdata[g]), .mem_ack(mem_ack[g]));
    always @(posedge clk) begin
      if (sys_rst) begin
        wlog_a[g].delete();
        wlog_d[g].delete();
        wlog_w[g].delete();
      end else if ((mem_req[g] & mem_ack[g] & mem_we[g]) === 1'b1) begin
        wlog_a[g].push_back(mem_addr[g]);
        wlog_d[g].push_back(mem_wdata[g]);
        wlog_w[g].push_back(mem_word[g]);
      end
      for (int i = 0; i < 4; i++) begin
        if (sys_rst) irq_n[g][i] = 0;
        else if (dma_irq[g][i] === 1'b1) irq_n[g][i]++;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------------
  function automatic fdc_count_type pat(input fdc_addr_type a);
    return a[15:0] ^ 16'h5a5a;
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (12) tick();
    sys_rst = 1'b0;
  endtask

  task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
    tick();
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask

  task automatic sfr_read(input logic [15:0] a, input logic [7:0] en, input logic [7:0] el);
    tick();
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick();
    sfr_rd = 1'b0;
    `CHK("select normal", en, sfr_rdata[0])
    `CHK("select legacy", el, sfr_rdata[1])
  endtask

  task automatic ldc_write(input logic [1:0] ch, input logic [2:0] code, input logic [23:0] d);
    tick();
    ldc_chan = ch;
    ldc_code = code;
    ldc_wdata = d;
    ldc_wr = 1'b1;
    tick();
    ldc_wr = 1'b0;
  endtask

  task automatic ldc_read(input logic [1:0] ch, input logic [2:0] code, input logic [23:0] en,
                          input logic [23:0] el, input bit leg);
    int n;
    tick();
    ldc_chan = ch;
    ldc_code = code;
    ldc_rd = 1'b1;
    tick();
    ldc_rd = 1'b0;
    n = 0;
    while (ldc_rvalid[0] !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    `CHK("load valid", 1'b1, ldc_rvalid[0])
    `CHK("load normal", en, ldc_rdata[0])
    if (leg) `CHK("load legacy", el, ldc_rdata[1])
  endtask

  // Bounded wait on the four-channel build's write log; three edges let the irq land
  task automatic wait_writes(input int n);
    int t;
    t = 0;
    while (wlog_a[0].size() < n && t < 60) begin
      tick();
      t++;
    end
    repeat (3) tick();
  endtask

  task automatic chk_wr(input int g, input int k, input fdc_addr_type a, input fdc_count_type d,
                        input logic w);
    fdc_count_type m;
    m = w ? 16'hffff : 16'h00ff;
    `CHK("write address", a, wlog_a[g][k])
    `CHK("write data", d & m, wlog_d[g][k] & m)
    `CHK("write unit", w, wlog_w[g][k])
  endtask

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    do_reset();
    for (int c = 0; c < 4; c++) sfr_read(`FDC_SEL0_ADDR + 16'(c), 8'h00, 8'h00);
    sfr_read(16'h0377, 8'h00, 8'h00);
    sfr_read(16'h037c, 8'h00, 8'h00);
    // Every source code on channel 2, which the legacy build refuses
    for (int s = 0; s < 32; s++) begin
      sfr_write(`FDC_SEL2_ADDR, 8'(s));
      sfr_read(`FDC_SEL2_ADDR, 8'(s), 8'h00);
    end
    sfr_write(`FDC_SEL0_ADDR, 8'h4f);
    sfr_read(`FDC_SEL0_ADDR, 8'h0f, 8'h4f);

    // Single mode, words, memory to fixed; the four-channel build must ignore the fourth request
    do_reset();
    ldc_write(2'h0, `FDC_LDC_MODE, 24'h000008);
    ldc_write(2'h0, `FDC_LDC_FIXED, 24'h123456);
    ldc_write(2'h0, `FDC_LDC_MEMADDR, 24'h0abc00);
    ldc_write(2'h0, `FDC_LDC_COUNT, 24'h000003);
    ldc_read(2'h0, `FDC_LDC_FIXED, 24'h123456, 24'h023456, 1'b1);
    ldc_read(2'h0, `FDC_LDC_MODE, 24'h000008, 24'h000008, 1'b1);
    for (int k = 0; k < 4; k++) begin
      sfr_write(`FDC_SEL0_ADDR, 8'h20);
      wait_writes(k + 1);
      `CHK("irq normal", (k >= 2) ? 1 : 0, irq_n[0][0])
      `CHK("irq legacy", (k == 3) ? 1 : 0, irq_n[1][0])
    end
    `CHK("transfers normal", 3, wlog_a[0].size())
    `CHK("transfers legacy", 4, wlog_a[1].size())
    for (int k = 0; k < 3; k++) chk_wr(0, k, 24'h123456, pat(24'h0abc00 + 24'(2 * k)), 1'b1);
    for (int k = 0; k < 4; k++) chk_wr(1, k, 24'h023456, pat(24'h0abc00 + 24'(2 * k)), 1'b1);
    ldc_read(2'h0, `FDC_LDC_COUNT, 24'h000000, 24'h000000, 1'b0);

    // Peripheral source on channel 3, bytes, fixed to memory, slow memory
    do_reset();
    wait_cycles = 4'h3;
    ldc_write(2'h3, `FDC_LDC_MODE, 24'h000001);
    ldc_write(2'h3, `FDC_LDC_FIXED, 24'h00f0f0);
    ldc_write(2'h3, `FDC_LDC_MEMADDR, 24'h200010);
    ldc_write(2'h3, `FDC_LDC_COUNT, 24'h000002);
    sfr_write(`FDC_SEL3_ADDR, 8'h05);
    sfr_read(`FDC_SEL3_ADDR, 8'h05, 8'h00);
    for (int k = 0; k < 2; k++) begin
      tick();
      periph_req[5] = 1'b1;
      tick();
      periph_req[5] = 1'b0;
      // A software request made while the first move waits shows as pending
      if (k == 0) begin
        sfr_write(`FDC_SEL3_ADDR, 8'h25);
        sfr_read(`FDC_SEL3_ADDR, 8'h85, 8'h00);
      end
      wait_writes(k + 2);
    end
    for (int k = 0; k < 2; k++) chk_wr(0, k, 24'h200010 + 24'(k), pat(24'h00f0f0), 1'b0);
    `CHK("irq ch3", 1, irq_n[0][3])
    `CHK("legacy ch3", 0, wlog_a[1].size())
    `CHK("writes ch3", 2, wlog_a[0].size())

    // Repeat mode on channel 1 reloads address and count after each block
    do_reset();
    wait_cycles = 4'h0;
    ldc_write(2'h1, `FDC_LDC_ADDR_RELOAD, 24'h002000);
    ldc_write(2'h1, `FDC_LDC_COUNT_RELOAD, 24'h000002);
    ldc_write(2'h1, `FDC_LDC_MODE, 24'h00000a);
    ldc_write(2'h1, `FDC_LDC_FIXED, 24'h000100);
    ldc_write(2'h1, `FDC_LDC_MEMADDR, 24'h001000);
    ldc_write(2'h1, `FDC_LDC_COUNT, 24'h000002);
    for (int k = 0; k < 3; k++) begin
      sfr_write(`FDC_SEL1_ADDR, 8'h20);
      wait_writes(k + 1);
    end
    chk_wr(0, 0, 24'h000100, pat(24'h001000), 1'b1);
    chk_wr(0, 1, 24'h000100, pat(24'h001002), 1'b1);
    chk_wr(0, 2, 24'h000100, pat(24'h002000), 1'b1);
    `CHK("irq ch1", 1, irq_n[0][1])
    ldc_read(2'h1, `FDC_LDC_MEMADDR, 24'h002002, 24'h000000, 1'b0);
    ldc_read(2'h1, `FDC_LDC_COUNT, 24'h000001, 24'h000000, 1'b0);
    ldc_read(2'h1, `FDC_LDC_ADDR_RELOAD, 24'h002000, 24'h002000, 1'b1);

    // Fixed-to-fixed only in the legacy build, where count zero still moves once
    ldc_write(2'h0, `FDC_LDC_MODE, 24'h000004);
    ldc_write(2'h0, `FDC_LDC_FIXED, 24'h000300);
    ldc_write(2'h0, `FDC_LDC_MEMADDR, 24'h000400);
    ldc_write(2'h0, `FDC_LDC_COUNT, 24'h000000);
    sfr_write(`FDC_SEL0_ADDR, 8'h20);
    wait_writes(4);
    `CHK("transfers zero count", 3, wlog_a[0].size())
    chk_wr(1, 3, 24'h000400, pat(24'h000300), 1'b0);
    ldc_read(2'h0, `FDC_LDC_MEMADDR, 24'h000400, 24'h000400, 1'b1);
    complete_run();
  end
endmodule // testbench
